/* File: codec_meter_loop_pkg.sv */
// constants for the codec meter, loopback and filter select registers
package codec_meter_loop_pkg;
  // serial command byte layout
  localparam int CMD_W = 8;
  localparam int CMD_DIR_BIT = 7;
  localparam int ADDR_W = 7;
  localparam int XFER_CMD_LAST = 7;
  localparam int XFER_LAST = 15;
  localparam logic [4:0] BITCNT_CMD_DONE = 5'h08;

  // register addresses (the read code; the write code adds the direction bit)
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_FILTER_SELECT = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_METER_RESULT_LOW = 7'h31;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_METER_RESULT_HIGH = 7'h32;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_METER_SAMPLE_COUNT = 7'h33;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_METER_CONFIG = 7'h34;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_LOOPBACK_POWER = 7'h35;

  // reset values
  localparam logic [7:0] FILTER_SELECT_RST = 8'h08;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] SAMPLE_COUNT_RST = 8'h00;
  localparam logic [7:0] METER_CONFIG_RST = 8'h00;
  localparam logic [7:0] LOOPBACK_POWER_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // channel_filter_select fields
  localparam int FS_RECEIVE_GAIN = 7;
  localparam int FS_RECEIVE_CORR = 6;
  localparam int FS_TRANSMIT_GAIN = 5;
  localparam int FS_TRANSMIT_CORR = 4;
  localparam int FS_HIGH_PASS = 3;
  localparam int FS_IMP_SCALING = 2;
  localparam int FS_ECHO_CANCEL = 1;
  localparam int FS_IMP_MATCH = 0;

  // level_meter_config fields
  localparam int MC_METER_ON = 3;
  localparam int MC_LINEAR = 2;
  localparam int MC_CHAN_LSB = 0;
  localparam int MC_CHAN_W = 2;
  localparam logic [7:0] MC_WRITE_MASK = 8'h0f;

  // global_loopback_power fields
  localparam int LP_PLL_SLEEP = 5;
  localparam int LP_DIG_AT_ANALOG = 4;
  localparam int LP_ANA_AT_FRAME = 3;
  localparam int LP_DIG_AT_FRAME = 2;
  localparam int LP_SERIAL_DIG = 1;
  localparam int LP_SERIAL_ANA = 0;
  localparam logic [7:0] LP_WRITE_MASK = 8'h3f;

  // meter_result_lower ready flag
  localparam int READY_BIT = 0;

  // frame timing
  localparam int FRAME_TIME_NS = 125000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FRAME_CYCLES_DEF = FRAME_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PH_CMD, PH_READ, PH_WRITE, PH_IGNORE} phase_t;
endpackage : codec_meter_loop_pkg

/* File: codec_meter_loopback_filter_regs.sv */
// control registers, level meter and serial control port of the four-channel codec
`timescale 1ns/1ps
// Function
// - command msb selects write, else read
// - result upper byte read-only, resets zero
// - zero count copies sample straight through
// - count N samples over N frames
// - meter runs only while enable set
// - compressed mode copies sample into upper byte
// - linear mode meters into both result bytes
// - two-bit field picks metered channel one-four
// - pll sleep stops internal clocks
// - digital loop at analog interface, reset off
// - analog loop at frame-rate interface, reset off
// - digital loop at frame-rate interface, reset off
// - receive highway looped to transmit highway
// - transmit highway looped to receive path
// - bits 7/5 enable receive/transmit gain
// - bit 6 enables receive response correction
// - bit 4 enables transmit response correction
// - bit 3 high-pass, resets to one
// - bit 2 enables impedance scaling gain
// - bit 1 enables echo canceller
// - bit 0 enables impedance matcher
// - ready flag set, cleared by upper read
module codec_meter_loopback_filter_regs
  import codec_meter_loop_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int SAMPLE_W = 16,
  parameter int FRAME_CYCLES = FRAME_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cclk,
  input wire logic cs_n,
  input wire logic cdata_in,
  output logic cdata_out,
  output logic cdata_oe_n,
  input wire logic [NUM_CH-1:0] channel_mask,
  input wire logic [NUM_CH*SAMPLE_W-1:0] sample_in,
  output logic [NUM_CH-1:0] receive_gain,
  output logic [NUM_CH-1:0] receive_response_correction,
  output logic [NUM_CH-1:0] transmit_gain,
  output logic [NUM_CH-1:0] transmit_response_correction,
  output logic [NUM_CH-1:0] high_pass_on,
  output logic [NUM_CH-1:0] impedance_scaling_gain,
  output logic [NUM_CH-1:0] echo_canceller,
  output logic [NUM_CH-1:0] impedance_matcher,
  output logic pll_sleep,
  output logic digital_loop_at_analog,
  output logic analog_loop_at_frame_rate,
  output logic digital_loop_at_frame_rate,
  output logic serial_digital_loop,
  output logic serial_analog_loop,
  output logic meter_on,
  output logic meter_frame_tick
);

  // lowest channel in the mask answers reads of the per-channel byte
  function automatic logic [MC_CHAN_W-1:0] first_channel(input logic [NUM_CH-1:0] m);
    logic [MC_CHAN_W-1:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = MC_CHAN_W'(i);
      end
    end
    return r;
  endfunction : first_channel

  // two's complement magnitude; the most negative code maps to itself
  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
    return s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
  endfunction : magnitude

  // pin synchronisers; stage 1 feeds only stage 2
  logic cclk_s1_q, cclk_s2_q;
  // third cclk flop only feeds the edge detectors
  logic cclk_s3_q;
  logic cs_s1_q, cs_s2_q, din_s1_q, din_s2_q;
  logic [NUM_CH-1:0] mask_s1_q, mask_s2_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cclk_s1_q <= '0;
      cclk_s2_q <= '0;
      cclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      mask_s1_q <= '0;
      mask_s2_q <= '0;
    end else begin
      cclk_s1_q <= cclk;
      cclk_s2_q <= cclk_s1_q;
      cclk_s3_q <= cclk_s2_q;
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      din_s1_q <= cdata_in;
      din_s2_q <= din_s1_q;
      mask_s1_q <= channel_mask;
      mask_s2_q <= mask_s1_q;
    end
  end

  wire cclk_rise = cclk_s2_q & ~cclk_s3_q;
  wire cclk_fall = ~cclk_s2_q & cclk_s3_q;
  wire selected = ~cs_s2_q;

  // serial transfer state
  phase_t phase_q, phase_d;
  logic [4:0] bitcnt_q;
  logic [CMD_W-1:0] shift_q, out_q;
  logic oe_n_q;
  logic [ADDR_W-1:0] addr_q;

  wire [CMD_W-1:0] shift_next = {shift_q[CMD_W-2:0], din_s2_q};
  wire [ADDR_W-1:0] cmd_addr = shift_next[ADDR_W-1:0];
  wire cmd_is_write = shift_next[CMD_DIR_BIT];
  // only the first byte of a frame is a command; the bit counter wraps on long frames
  wire in_cmd = phase_q == PH_CMD;
  wire cmd_done = selected & cclk_rise & in_cmd & (bitcnt_q == 5'(XFER_CMD_LAST));
  wire data_done = selected & cclk_rise & (bitcnt_q == 5'(XFER_LAST));

  // registers
  logic [7:0] filter_q [NUM_CH];
  logic [7:0] count_q, config_q, loop_q, res_hi_q, res_lo_q;
  logic ready_q;

  // read-only and unknown codes fall back to ignoring the data byte
  wire cmd_writable = (cmd_addr == ADDR_CHANNEL_FILTER_SELECT) |
                      (cmd_addr == ADDR_LEVEL_METER_SAMPLE_COUNT) |
                      (cmd_addr == ADDR_LEVEL_METER_CONFIG) |
                      (cmd_addr == ADDR_GLOBAL_LOOPBACK_POWER);

  logic [7:0] read_data;
  always_comb begin
    if (cmd_addr == ADDR_CHANNEL_FILTER_SELECT) begin
      read_data = filter_q[first_channel(mask_s2_q)];
    end else if (cmd_addr == ADDR_METER_RESULT_LOW) begin
      read_data = {res_lo_q[7:1], ready_q};
    end else if (cmd_addr == ADDR_LEVEL_METER_RESULT_HIGH) begin
      read_data = res_hi_q;
    end else if (cmd_addr == ADDR_LEVEL_METER_SAMPLE_COUNT) begin
      read_data = count_q;
    end else if (cmd_addr == ADDR_LEVEL_METER_CONFIG) begin
      read_data = config_q & MC_WRITE_MASK;
    end else if (cmd_addr == ADDR_GLOBAL_LOOPBACK_POWER) begin
      read_data = loop_q & LP_WRITE_MASK;
    end else begin
      read_data = READ_UNMAPPED;
    end
  end

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_CMD: begin
        if (cmd_done) begin
          if (!cmd_is_write) begin
            phase_d = PH_READ;
          end else if (cmd_writable) begin
            phase_d = PH_WRITE;
          end else begin
            phase_d = PH_IGNORE;
          end
        end
      end
      default: begin
        if (data_done) begin
          phase_d = PH_IGNORE;
        end
      end
    endcase
    if (!selected) begin
      phase_d = PH_CMD;
    end
  end

  wire wr_strobe = data_done & (phase_q == PH_WRITE);
  wire wr_filter = wr_strobe & (addr_q == ADDR_CHANNEL_FILTER_SELECT);
  wire wr_count = wr_strobe & (addr_q == ADDR_LEVEL_METER_SAMPLE_COUNT);
  wire wr_config = wr_strobe & (addr_q == ADDR_LEVEL_METER_CONFIG);
  wire wr_loop = wr_strobe & (addr_q == ADDR_GLOBAL_LOOPBACK_POWER);
  // the flag drops as the upper-byte command completes, before its data goes out
  wire rd_high = cmd_done & ~cmd_is_write & (cmd_addr == ADDR_LEVEL_METER_RESULT_HIGH);
  // data leaves on falling edges; the msb is already out after the command
  wire rd_shift = selected & cclk_fall & (phase_q == PH_READ) & (bitcnt_q > BITCNT_CMD_DONE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_CMD;
      bitcnt_q <= '0;
      shift_q <= '0;
      addr_q <= '0;
    end else begin
      phase_q <= phase_d;
      bitcnt_q <= !selected ? '0 : (cclk_rise ? bitcnt_q + 5'h01 : bitcnt_q);
      shift_q <= (selected & cclk_rise) ? shift_next : shift_q;
      addr_q <= cmd_done ? cmd_addr : addr_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      if (cmd_done & ~cmd_is_write) begin
        out_q <= read_data;
        oe_n_q <= 1'b0;
      end else if (rd_shift) begin
        out_q <= {out_q[CMD_W-2:0], 1'b0};
      end
      if (!selected || data_done) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  assign cdata_out = out_q[CMD_W-1];
  assign cdata_oe_n = oe_n_q;

  // per-channel filter select; a write lands in every masked channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        filter_q[c] <= FILTER_SELECT_RST;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_filter && mask_s2_q[c]) begin
          filter_q[c] <= shift_next;
        end
      end
    end
  end

  // no cross-check of bits 0 and 2: the host owns that pairing
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    assign receive_gain[c] = filter_q[c][FS_RECEIVE_GAIN];
    assign receive_response_correction[c] = filter_q[c][FS_RECEIVE_CORR];
    assign transmit_gain[c] = filter_q[c][FS_TRANSMIT_GAIN];
    assign transmit_response_correction[c] = filter_q[c][FS_TRANSMIT_CORR];
    assign high_pass_on[c] = filter_q[c][FS_HIGH_PASS];
    assign impedance_scaling_gain[c] = filter_q[c][FS_IMP_SCALING];
    assign echo_canceller[c] = filter_q[c][FS_ECHO_CANCEL];
    assign impedance_matcher[c] = filter_q[c][FS_IMP_MATCH];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= SAMPLE_COUNT_RST;
      config_q <= METER_CONFIG_RST;
      loop_q <= LOOPBACK_POWER_RST;
    end else begin
      count_q <= wr_count ? shift_next : count_q;
      config_q <= wr_config ? (shift_next & MC_WRITE_MASK) : config_q;
      loop_q <= wr_loop ? (shift_next & LP_WRITE_MASK) : loop_q;
    end
  end

  assign pll_sleep = loop_q[LP_PLL_SLEEP];
  assign digital_loop_at_analog = loop_q[LP_DIG_AT_ANALOG];
  assign analog_loop_at_frame_rate = loop_q[LP_ANA_AT_FRAME];
  assign digital_loop_at_frame_rate = loop_q[LP_DIG_AT_FRAME];
  assign serial_digital_loop = loop_q[LP_SERIAL_DIG];
  assign serial_analog_loop = loop_q[LP_SERIAL_ANA];
  assign meter_on = config_q[MC_METER_ON];

  // frame timer; frozen while the pll sleeps, since its clocks are gone
  logic [31:0] frame_cnt_q;
  logic tick_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (pll_sleep) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (frame_cnt_q == 32'(FRAME_CYCLES - 1));
      frame_cnt_q <= (frame_cnt_q == 32'(FRAME_CYCLES - 1)) ? '0 : frame_cnt_q + 32'h1;
    end
  end
  assign meter_frame_tick = tick_q;

  // level meter
  wire [MC_CHAN_W-1:0] chan = config_q[MC_CHAN_LSB +: MC_CHAN_W];
  wire [SAMPLE_W-1:0] sample_sel = sample_in[chan*SAMPLE_W +: SAMPLE_W];
  wire [SAMPLE_W-1:0] mag = magnitude(sample_sel);
  wire linear = config_q[MC_LINEAR];
  wire step = tick_q & meter_on;
  logic [7:0] frames_q;
  logic [SAMPLE_W-1:0] peak_q;
  wire [SAMPLE_W-1:0] peak_now = (mag > peak_q) ? mag : peak_q;
  wire last_frame = (frames_q + 8'h01) == count_q;
  wire direct = count_q == SAMPLE_COUNT_RST;
  wire latch_lin = step & linear & (direct | last_frame);
  wire latch_cmp = step & ~linear;
  wire [SAMPLE_W-1:0] lin_result = direct ? sample_sel : peak_now;

  // disabling the meter or a zero count drops the partial interval
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frames_q <= '0;
      peak_q <= '0;
    end else if (!meter_on || !linear || direct) begin
      frames_q <= '0;
      peak_q <= '0;
    end else if (step) begin
      frames_q <= last_frame ? '0 : frames_q + 8'h01;
      peak_q <= last_frame ? '0 : peak_now;
    end
  end

  // linear mode changes both bytes in the same edge, but a read pair can still straddle intervals; compressed mode writes only the upper byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_hi_q <= RESULT_RST;
      res_lo_q <= RESULT_RST;
    end else if (latch_lin) begin
      res_hi_q <= lin_result[SAMPLE_W-1 -: 8];
      res_lo_q <= lin_result[7:0];
    end else if (latch_cmp) begin
      res_hi_q <= sample_sel[7:0];
    end
  end

  // a new result in the same cycle as the upper read keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (latch_lin | latch_cmp) | (ready_q & ~rd_high);
    end
  end

endmodule : codec_meter_loopback_filter_regs

/* File: host_serial_model.sv */
// behavioural host on the serial control port
`timescale 1ns/1ps
module host_serial_model (
  input wire logic clk_sys,
  output logic cclk,
  output logic cs_n,
  output logic cdata_in,
  input wire logic cdata_out,
  input wire logic cdata_oe_n
);
  // cclk half period in clk_sys cycles; raised by the bench for a slow host
  int phase = 6;
  initial begin
    cclk = 1'b0;
    cs_n = 1'b1;
    cdata_in = 1'b0;
  end
  task automatic tick;
    repeat (phase) @(posedge clk_sys);
  endtask : tick
  // command byte, msb first, top bit is the direction
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    cs_n <= 1'b0;
    tick();
    for (int i = 15; i >= 0; i--) begin
      cdata_in <= w[i];
      cclk <= 1'b0;
      tick();
      if (i < 8) r[i] = cdata_oe_n ? 1'bx : cdata_out;
      cclk <= 1'b1;
      tick();
    end
    cclk <= 1'b0;
    tick();
    cs_n <= 1'b1;
    // released line flips so a stale bit never passes for data
    cdata_in <= ~cdata_in;
    tick();
  endtask : xfer
endmodule : host_serial_model

/* File: codec_meter_chk.sv */
// port assertions for the codec meter and loopback registers
`timescale 1ns/1ps
module codec_meter_chk #(
  parameter int NUM_CH = 4,
  parameter int FRAME_CYCLES = 25000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic cdata_oe_n,
  input wire logic [NUM_CH-1:0] receive_gain,
  input wire logic [NUM_CH-1:0] high_pass_on,
  input wire logic [NUM_CH-1:0] impedance_matcher,
  input wire logic pll_sleep,
  input wire logic digital_loop_at_analog,
  input wire logic serial_analog_loop,
  input wire logic meter_on,
  input wire logic meter_frame_tick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int gap_q;
  logic seen_q;
  // a sleep spell voids the gap measurement
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= meter_frame_tick ? 0 : gap_q + 1;
      seen_q <= !pll_sleep && (meter_frame_tick || seen_q);
    end
  end
  property p_oe_idle;
    cs_n [*7] |-> cdata_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data out driven while idle");
  property p_oe_sel;
    $fell(cdata_oe_n) |-> !cs_n && !$past(cs_n, 4);
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("data out without select");
  property p_tick_sep;
    meter_frame_tick |=> !meter_frame_tick [*8];
  endproperty
  a_tick_sep: assert property (p_tick_sep) else $error("frame tick too soon");
  property p_tick_gap;
    meter_frame_tick && seen_q && !pll_sleep |-> gap_q == FRAME_CYCLES - 1;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("frame period wrong");
  property p_sleep;
    pll_sleep && $past(pll_sleep) |-> !meter_frame_tick;
  endproperty
  a_sleep: assert property (p_sleep) else $error("tick while asleep");
  property p_hold;
    cs_n [*8] |-> $stable(receive_gain) && $stable(high_pass_on) && $stable(meter_on);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved without access");
  property p_rst_filt;
    $rose(rst_n) |-> high_pass_on == '1 && receive_gain == '0 && impedance_matcher == '0;
  endproperty
  a_rst_filt: assert property (p_rst_filt) else $error("filter reset value");
  property p_rst_loop;
    $rose(rst_n) |-> !(pll_sleep || digital_loop_at_analog || serial_analog_loop || meter_on);
  endproperty
  a_rst_loop: assert property (p_rst_loop) else $error("loop reset value");
  c_tick: cover property (meter_frame_tick);
  c_read: cover property ($fell(cdata_oe_n));
  c_sleep: cover property ($rose(pll_sleep));
endmodule : codec_meter_chk
bind codec_meter_loopback_filter_regs codec_meter_chk #(
  .NUM_CH(NUM_CH),
  .FRAME_CYCLES(FRAME_CYCLES)
) u_chk (.clk_sys, .rst_n, .cs_n, .cdata_oe_n, .receive_gain, .high_pass_on,
  .impedance_matcher, .pll_sleep, .digital_loop_at_analog, .serial_analog_loop, .meter_on,
  .meter_frame_tick);

/* File: tb_codec_meter_loopback_filter_regs.sv */
// bench for the codec meter, loopback and filter select registers
`timescale 1ns/1ps
module tb_codec_meter_loopback_filter_regs;
  localparam int FC = 20;
  typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic clk_sys, rst_n, cclk, cs_n, cdata_in, cdata_out, cdata_oe_n, pll_sleep, meter_on;
  logic [3:0] channel_mask, receive_gain, receive_response_correction, transmit_gain;
  logic [3:0] transmit_response_correction, high_pass_on, impedance_scaling_gain;
  logic [3:0] echo_canceller, impedance_matcher;
  logic [63:0] sample_in;
  logic digital_loop_at_analog, analog_loop_at_frame_rate, digital_loop_at_frame_rate;
  logic serial_digital_loop, serial_analog_loop, meter_frame_tick;
  logic [7:0] rdat;
  int n_mismatch = 0;
  int samples_checked = 0;
  // filter rows keep b0 equal to b2
  row_t rows[9] = '{'{7'h32, 8'hff, 8'h00}, '{7'h10, 8'hff, 8'h00}, '{7'h00, 8'ha5, 8'ha5},
    '{7'h00, 8'h5a, 8'h5a}, '{7'h33, 8'hff, 8'hff}, '{7'h35, 8'h3f, 8'h3f},
    '{7'h35, 8'hc0, 8'h00}, '{7'h34, 8'hff, 8'h0f}, '{7'h34, 8'h00, 8'h00}};
  logic [6:0] rst_a[6] = '{7'h00, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35};
  logic [7:0] rst_e[6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  wire [7:0] loops = {2'b00, pll_sleep, digital_loop_at_analog, analog_loop_at_frame_rate,
    digital_loop_at_frame_rate, serial_digital_loop, serial_analog_loop};
  codec_meter_loopback_filter_regs #(.FRAME_CYCLES(FC)) uut (.clk_sys, .rst_n, .cclk, .cs_n,
    .cdata_in, .cdata_out, .cdata_oe_n, .channel_mask, .sample_in, .receive_gain,
    .receive_response_correction, .transmit_gain, .transmit_response_correction,
    .high_pass_on, .impedance_scaling_gain, .echo_canceller, .impedance_matcher, .pll_sleep,
    .digital_loop_at_analog, .analog_loop_at_frame_rate, .digital_loop_at_frame_rate,
    .serial_digital_loop, .serial_analog_loop, .meter_on, .meter_frame_tick);
  host_serial_model host (.clk_sys, .cclk, .cs_n, .cdata_in, .cdata_out, .cdata_oe_n);
  function automatic logic [7:0] fsel(input int c);
    return {receive_gain[c], receive_response_correction[c], transmit_gain[c],
      transmit_response_correction[c], high_pass_on[c], impedance_scaling_gain[c],
      echo_canceller[c], impedance_matcher[c]};
  endfunction : fsel
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, rdat);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    host.xfer({1'b0, a, 8'h00}, rdat);
    check($sformatf("reg %h", a), rdat, e);
  endtask : rdchk
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // a hang is cut well beyond the expected ~17300 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
  initial begin
    channel_mask <= 4'hf;
    sample_in <= 64'h0;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
      for (int c = 0; c < 4; c++) begin
        if (rows[i].a == 7'h00) begin
          check("filter", fsel(c), rows[i].e);
        end
      end
      if (rows[i].a == 7'h35) check("loops", loops, rows[i].e);
      if (rows[i].a == 7'h34) check("meter_on", {4'h0, meter_on, 3'h0}, rows[i].e & 8'h08);
    end
    $display("register table test done");
    wr(7'h33, 8'h00);
    sample_in <= 64'h4d4c_3b3a_2b2a_1b1a;
    for (int c = 0; c < 4; c++) begin
      wr(7'h34, 8'h08 | 8'(c));
      wr(7'h34, 8'(c));
      rdchk(7'h31, 8'h01);
      rdchk(7'h32, sample_in[c*16 +: 8]);
    end
    sample_in <= 64'h0;
    rdchk(7'h32, 8'h4c);
    rdchk(7'h31, 8'h00);
    $display("compressed test done");
    sample_in <= 64'h9a36;
    wr(7'h34, 8'h0c);
    wr(7'h34, 8'h04);
    rdchk(7'h31, 8'h37);
    rdchk(7'h32, 8'h9a);
    sample_in <= 64'hf000;
    wr(7'h33, 8'hff);
    wr(7'h34, 8'h0c);
    rdchk(7'h31, 8'h36);
    repeat (255 * FC) @(posedge clk_sys);
    rdchk(7'h31, 8'h01);
    rdchk(7'h32, 8'h10);
    $display("linear test done");
    channel_mask <= 4'h4;
    wr(7'h00, 8'h85);
    rdchk(7'h00, 8'h85);
    check("filter", fsel(2), 8'h85);
    check("filter", fsel(0), 8'h5a);
    channel_mask <= 4'hf;
    $display("channel mask test done");
    wr(7'h35, 8'h3f);
    do_reset();
    host.phase = 9;
    foreach (rst_a[i]) rdchk(rst_a[i], rst_e[i]);
    check("filter", fsel(3), 8'h08);
    check("loops", loops, 8'h00);
    $display("reset test done");
    complete_run();
  end
endmodule : tb_codec_meter_loopback_filter_regs
